// ==== hdl/rcac_chan.sv ====
`timescale 1ns/100ps
`default_nettype none
module rcac_chan (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [15:0] ctrl,
    input  wire logic [15:0] win,
    input  wire logic        sync_in,
    input  wire logic        soft_sync,
    input  wire logic        trig_clear,
    input  wire logic [13:0] adc_data,
    output logic             acq_active,
    output logic [8:0]       acc_count,
    output logic             out_valid,
    output logic [13:0]      out_data,
    input  wire logic        out_ready
);
    typedef struct packed {
        rcac_pkg::rcac_acq_t st;
        logic [16:0]         cnt;
        logic [13:0]         pat;
        logic [1:0]          bvld;
        logic [13:0]         b0;
        logic [13:0]         b1;
    } rcac_chan_t;

    rcac_chan_t s_ff;
    rcac_chan_t nxt_s;
    logic [1:0]  trig;
    logic        free_run;
    logic [16:0] burst;
    logic [13:0] sample;
    logic        push;
    logic        pop;
    logic        room;

    // ****************************************************************
    // Mode decode.
    // ****************************************************************
    assign trig     = ctrl[rcac_pkg::POS_TRIG +: 2];
    assign free_run = ctrl[rcac_pkg::POS_FREE];
    assign burst    = {ctrl[rcac_pkg::POS_MSB], win};
    assign acc_count = (ctrl[rcac_pkg::POS_ACC +: 4] >= rcac_pkg::ACC_MAX_CODE) ? 9'h100
                     : 9'(9'h001 << ctrl[rcac_pkg::POS_ACC +: 3]);
    assign sample   = ctrl[rcac_pkg::POS_TEST] ? s_ff.pat : adc_data;
    assign room     = (s_ff.bvld != 2'h3);
    assign push     = (s_ff.st == rcac_pkg::RCAC_ACQ) && room;
    assign pop      = s_ff.bvld[0] && out_ready;
    assign acq_active = (s_ff.st == rcac_pkg::RCAC_ACQ);
    assign out_valid  = s_ff.bvld[0];
    assign out_data   = s_ff.b0;

    always_comb begin
        nxt_s = s_ff;
        if (ctrl[rcac_pkg::POS_TEST]) begin
            nxt_s.pat = 14'(s_ff.pat + 14'h0001);
        end
        unique case (s_ff.st)
            rcac_pkg::RCAC_IDLE: begin
                if (trig == rcac_pkg::TRIG_BURST && (sync_in || soft_sync)) begin
                    nxt_s.st  = rcac_pkg::RCAC_ACQ;
                    nxt_s.cnt = 17'h00000;
                end else if (trig[1] && sync_in) begin
                    nxt_s.st  = rcac_pkg::RCAC_ACQ;
                    nxt_s.cnt = 17'h00000;
                end
            end
            rcac_pkg::RCAC_ACQ: begin
                if (push) begin
                    nxt_s.cnt = 17'(s_ff.cnt + 17'h00001);
                end
                if (trig == rcac_pkg::TRIG_OFF) begin
                    nxt_s.st = rcac_pkg::RCAC_IDLE;
                end else if (trig[1]) begin
                    if (!sync_in) begin
                        nxt_s.st = rcac_pkg::RCAC_IDLE;
                    end
                end else if (trig_clear) begin
                    nxt_s.st = rcac_pkg::RCAC_IDLE;
                end else if (!free_run && push && s_ff.cnt == burst) begin
                    nxt_s.st = rcac_pkg::RCAC_IDLE;
                end
            end
        endcase
        unique case ({push, pop})
            2'b10: begin
                if (s_ff.bvld[0]) begin
                    nxt_s.b1   = sample;
                    nxt_s.bvld = 2'h3;
                end else begin
                    nxt_s.b0   = sample;
                    nxt_s.bvld = 2'h1;
                end
            end
            2'b01: begin
                nxt_s.b0   = s_ff.b1;
                nxt_s.bvld = {1'b0, s_ff.bvld[1]};
            end
            2'b11: begin
                if (s_ff.bvld[1]) begin
                    nxt_s.b0 = s_ff.b1;
                    nxt_s.b1 = sample;
                end else begin
                    nxt_s.b0 = sample;
                end
            end
            2'b00: begin
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end
endmodule : rcac_chan
`default_nettype wire

// ==== hdl/rcac_pkg.sv ====
package rcac_pkg;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [19:0] OFS_CTRL_EVEN   = 20'h10008;
    localparam logic [19:0] OFS_WIN_EVEN    = 20'h1000c;
    localparam logic [19:0] OFS_DEC_ODD     = 20'h10010;
    localparam logic [19:0] OFS_CTRL_ODD    = 20'h10014;
    localparam logic [19:0] OFS_WIN_ODD     = 20'h10018;
    localparam logic [19:0] OFS_GAIN        = 20'h1001c;
    localparam logic [19:0] OFS_RX_BASE     = 20'h12000;
    localparam logic [19:0] OFS_RX_END      = 20'h19ffc;

    // ****************************************************************
    // Field positions and masks.
    // ****************************************************************
    localparam logic [15:0] MASK_DEC        = 16'h3fff;
    localparam logic [15:0] MASK_CTRL       = 16'h0fff;
    localparam logic [15:0] MASK_GAIN       = 16'h0fff;
    localparam int          POS_MODE        = 0;
    localparam int          POS_ACC         = 3;
    localparam int          POS_TRIG        = 7;
    localparam int          POS_FREE        = 9;
    localparam int          POS_TEST        = 10;
    localparam int          POS_MSB         = 11;
    localparam int          POS_TCLR        = 15;
    localparam int          POS_PATH_EVEN   = 0;
    localparam int          POS_PATH_ODD    = 1;
    localparam int          POS_GAIN_EVEN   = 2;
    localparam int          POS_GAIN_ODD    = 7;

    // ****************************************************************
    // Reset values and encodings.
    // ****************************************************************
    localparam logic [15:0] RST_REG         = 16'h0000;
    localparam logic [1:0]  TRIG_OFF        = 2'h0;
    localparam logic [1:0]  TRIG_BURST      = 2'h1;
    localparam logic [3:0]  ACC_MAX_CODE    = 4'h8;
    localparam logic [1:0]  AXI_OKAY        = 2'h0;
    localparam logic [1:0]  AXI_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        RCAC_IDLE = 2'b00,
        RCAC_ACQ  = 2'b01
    } rcac_acq_t;

endpackage : rcac_pkg

// ==== hdl/rcac_top.sv ====
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Burst count is 17 bits: window size low, control MSB bit on top.
// - Host writes words minus one; each trigger acquires count plus one words.
// - Three-bit mode field selects the data path variant.
// - Accumulate code n gives two to the n, codes eight up give 256.
// - Trigger code 00 disables; 01 starts on external or software sync.
// - Code 01 ends at burst end, or at trigger clear in either free-run setting.
// - Gate mode acquires while sync is active, stops when it drops.
// - Free run clear limits by burst count; set collects continuously.
// - Test bit selects converter samples or an incrementing counter.
// - Trigger clear is write-only; a 1 stops a code 01 acquisition.
// - Per-channel path bit: 0 bypasses gain, 1 applies programmed gain.
// - Five-bit gain code, 1 dB steps, -12 dB to +19 dB, gain path only.
// - Each chip register is two 16-bit accesses: low at word, high at plus four.
// - Upper-half write joins held lower half and programs the chip.
module rcac_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [19:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [19:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sync_pin,
    input  wire logic        soft_sync,
    input  wire logic [13:0] adc_even,
    input  wire logic [13:0] adc_odd,
    output logic [2:0]       mode_even,
    output logic [2:0]       mode_odd,
    output logic [8:0]       acc_even,
    output logic [8:0]       acc_odd,
    output logic [13:0]      decim_odd,
    output logic             gain_path_even,
    output logic             gain_path_odd,
    output logic [4:0]       gain_even,
    output logic [4:0]       gain_odd,
    output logic             acq_even,
    output logic             acq_odd,
    output logic             even_valid,
    output logic [13:0]      even_data,
    input  wire logic        even_ready,
    output logic             odd_valid,
    output logic [13:0]      odd_data,
    input  wire logic        odd_ready,
    output logic             rx_wr_stb,
    output logic [12:0]      rx_wr_addr,
    output logic [31:0]      rx_wr_data,
    output logic [1:0]       rx_chip_sel,
    input  wire logic [31:0] rx_rd_data
);
    typedef struct packed {
        logic        aw_v;
        logic [19:0] aw_a;
        logic        w_v;
        logic [31:0] w_d;
        logic        b_v;
        logic [1:0]  b_r;
        logic        r_v;
        logic [1:0]  r_r;
        logic [31:0] r_d;
        logic [15:0] ctrl_e;
        logic [15:0] win_e;
        logic [15:0] dec_o;
        logic [15:0] ctrl_o;
        logic [15:0] win_o;
        logic [15:0] gain;
        logic        tclr_e;
        logic        tclr_o;
        logic [15:0] lo_hold;
        logic [15:0] hi_read;
        logic        wr_stb;
        logic [12:0] wr_a;
        logic [31:0] wr_d;
        logic [1:0]  sel;
        logic [1:0]  sync_s;
    } rcac_top_t;

    rcac_top_t s_ff;
    rcac_top_t nxt_s;
    logic      wr_go;
    logic      rx_w;
    logic      rx_r;
    logic      w_ok;

    // ****************************************************************
    // Acquisition channels.
    // ****************************************************************
    rcac_chan u_even (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .ctrl       (s_ff.ctrl_e),
        .win        (s_ff.win_e),
        .sync_in    (s_ff.sync_s[1]),
        .soft_sync  (soft_sync),
        .trig_clear (s_ff.tclr_e),
        .adc_data   (adc_even),
        .acq_active (acq_even),
        .acc_count  (acc_even),
        .out_valid  (even_valid),
        .out_data   (even_data),
        .out_ready  (even_ready)
    );

    rcac_chan u_odd (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .ctrl       (s_ff.ctrl_o),
        .win        (s_ff.win_o),
        .sync_in    (s_ff.sync_s[1]),
        .soft_sync  (soft_sync),
        .trig_clear (s_ff.tclr_o),
        .adc_data   (adc_odd),
        .acq_active (acq_odd),
        .acc_count  (acc_odd),
        .out_valid  (odd_valid),
        .out_data   (odd_data),
        .out_ready  (odd_ready)
    );

    // ****************************************************************
    // Register outputs.
    // ****************************************************************
    assign mode_even      = s_ff.ctrl_e[rcac_pkg::POS_MODE +: 3];
    assign mode_odd       = s_ff.ctrl_o[rcac_pkg::POS_MODE +: 3];
    assign decim_odd      = s_ff.dec_o[13:0];
    assign gain_path_even = s_ff.gain[rcac_pkg::POS_PATH_EVEN];
    assign gain_path_odd  = s_ff.gain[rcac_pkg::POS_PATH_ODD];
    assign gain_even      = s_ff.gain[rcac_pkg::POS_GAIN_EVEN +: 5];
    assign gain_odd       = s_ff.gain[rcac_pkg::POS_GAIN_ODD +: 5];
    assign s_axi_awready  = !s_ff.aw_v && !s_ff.b_v;
    assign s_axi_wready   = !s_ff.w_v && !s_ff.b_v;
    assign s_axi_bvalid   = s_ff.b_v;
    assign s_axi_bresp    = s_ff.b_r;
    assign s_axi_arready  = !s_ff.r_v;
    assign s_axi_rvalid   = s_ff.r_v;
    assign s_axi_rresp    = s_ff.r_r;
    assign s_axi_rdata    = s_ff.r_d;
    assign rx_wr_stb      = s_ff.wr_stb;
    assign rx_wr_addr     = s_ff.wr_a;
    assign rx_wr_data     = s_ff.wr_d;
    assign rx_chip_sel    = s_ff.sel;

    // ****************************************************************
    // Write decode, read decode and receiver bridge.
    // ****************************************************************
    assign wr_go = s_ff.aw_v && s_ff.w_v && !s_ff.b_v;
    assign rx_w  = (s_ff.aw_a >= rcac_pkg::OFS_RX_BASE) && (s_ff.aw_a <= rcac_pkg::OFS_RX_END);
    assign rx_r  = (s_axi_araddr >= rcac_pkg::OFS_RX_BASE)
                && (s_axi_araddr <= rcac_pkg::OFS_RX_END);
    assign w_ok  = (s_ff.w_d[3:0] != 4'h0);

    always_comb begin
        nxt_s        = s_ff;
        nxt_s.tclr_e = 1'b0;
        nxt_s.tclr_o = 1'b0;
        nxt_s.wr_stb = 1'b0;
        nxt_s.sync_s = {s_ff.sync_s[0], sync_pin};
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_s.aw_v = 1'b1;
            nxt_s.aw_a = {s_axi_awaddr[19:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_s.w_v = 1'b1;
            nxt_s.w_d = {s_axi_wdata[31:16], s_axi_wdata[15:0]};
            nxt_s.w_d[3:0] = s_axi_wstrb;
            nxt_s.w_d[31:16] = s_axi_wdata[15:0];
        end
        if (wr_go) begin
            nxt_s.aw_v = 1'b0;
            nxt_s.w_v  = 1'b0;
            nxt_s.b_v  = 1'b1;
            nxt_s.b_r  = rcac_pkg::AXI_OKAY;
            if (!w_ok) begin
            end else if (rx_w) begin
                if (!s_ff.aw_a[2]) begin
                    nxt_s.lo_hold = s_ff.w_d[31:16];
                end else begin
                    nxt_s.wr_stb = 1'b1;
                    nxt_s.wr_d   = {s_ff.w_d[31:16], s_ff.lo_hold};
                    nxt_s.wr_a   = {s_ff.aw_a[12:3], 3'b000};
                    nxt_s.sel    = 2'(s_ff.aw_a[15:13] - 3'h1);
                end
            end else begin
                unique case (s_ff.aw_a)
                    rcac_pkg::OFS_CTRL_EVEN: begin
                        nxt_s.ctrl_e = s_ff.w_d[31:16] & rcac_pkg::MASK_CTRL;
                        nxt_s.tclr_e = s_ff.w_d[16 + rcac_pkg::POS_TCLR];
                    end
                    rcac_pkg::OFS_WIN_EVEN: nxt_s.win_e = s_ff.w_d[31:16];
                    rcac_pkg::OFS_DEC_ODD:  nxt_s.dec_o = s_ff.w_d[31:16] & rcac_pkg::MASK_DEC;
                    rcac_pkg::OFS_CTRL_ODD: begin
                        nxt_s.ctrl_o = s_ff.w_d[31:16] & rcac_pkg::MASK_CTRL;
                        nxt_s.tclr_o = s_ff.w_d[16 + rcac_pkg::POS_TCLR];
                    end
                    rcac_pkg::OFS_WIN_ODD:  nxt_s.win_o = s_ff.w_d[31:16];
                    rcac_pkg::OFS_GAIN:     nxt_s.gain  = s_ff.w_d[31:16] & rcac_pkg::MASK_GAIN;
                    default:                nxt_s.b_r   = rcac_pkg::AXI_SLVERR;
                endcase
            end
        end
        if (s_ff.b_v && s_axi_bready) begin
            nxt_s.b_v = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_s.r_v = 1'b1;
            nxt_s.r_r = rcac_pkg::AXI_OKAY;
            nxt_s.r_d = 32'h00000000;
            if (rx_r) begin
                if (!s_axi_araddr[2]) begin
                    nxt_s.r_d     = {16'h0000, rx_rd_data[15:0]};
                    nxt_s.hi_read = rx_rd_data[31:16];
                end else begin
                    nxt_s.r_d = {16'h0000, s_ff.hi_read};
                end
            end else begin
                unique case ({s_axi_araddr[19:2], 2'b00})
                    rcac_pkg::OFS_CTRL_EVEN: nxt_s.r_d = {16'h0000, s_ff.ctrl_e};
                    rcac_pkg::OFS_WIN_EVEN:  nxt_s.r_d = {16'h0000, s_ff.win_e};
                    rcac_pkg::OFS_DEC_ODD:   nxt_s.r_d = {16'h0000, s_ff.dec_o};
                    rcac_pkg::OFS_CTRL_ODD:  nxt_s.r_d = {16'h0000, s_ff.ctrl_o};
                    rcac_pkg::OFS_WIN_ODD:   nxt_s.r_d = {16'h0000, s_ff.win_o};
                    rcac_pkg::OFS_GAIN:      nxt_s.r_d = {16'h0000, s_ff.gain};
                    default:                 nxt_s.r_r = rcac_pkg::AXI_SLVERR;
                endcase
            end
        end else if (s_ff.r_v && s_axi_rready) begin
            nxt_s.r_v = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end
endmodule : rcac_top
`default_nettype wire

// ==== verification/rcac_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bus, bridge and stream checks seen at the block's ports.
// ****************************************************************
module rcac_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [8:0]  acc_even,
    input wire logic        even_valid,
    input wire logic [13:0] even_data,
    input wire logic        even_ready,
    input wire logic        rx_wr_stb,
    input wire logic [31:0] rx_wr_data,
    input wire logic [1:0]  rx_chip_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    chk_b_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("no write answer");
    chk_r_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    chk_b_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    chk_stb_pulse:
    assert property (rx_wr_stb |=> !rx_wr_stb) else $error("chip strobe too long");
    chk_stb_resp:
    assert property (rx_wr_stb |-> s_axi_bvalid && s_axi_bresp == rcac_pkg::AXI_OKAY)
        else $error("chip strobe without write answer");
    chk_stb_hold:
    assert property (rx_wr_stb |=> ($stable(rx_wr_data) && $stable(rx_chip_sel)) [*2])
        else $error("chip word not held");
    chk_acc_pow:
    assert property (aresetn [*3] |-> $onehot(acc_even)) else $error("accumulate count bad");
    chk_stream_hold:
    assert property (even_valid && !even_ready |=> even_valid && $stable(even_data))
        else $error("stream word not held");
endmodule : rcac_monitor

bind rcac_top rcac_monitor i_mon (.*);
`default_nettype wire

// ==== verification/rcac_rx_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Receiver chip model: keeps the last programmed word and target.
// ****************************************************************
module rcac_rx_model (
    input  wire logic        aclk,
    input  wire logic        rx_wr_stb,
    input  wire logic [12:0] rx_wr_addr,
    input  wire logic [31:0] rx_wr_data,
    input  wire logic [1:0]  rx_chip_sel,
    output logic [31:0]      rx_rd_data,
    output int               n_wr,
    output logic [12:0]      lw_addr,
    output logic [1:0]       lw_sel
);
    initial begin
        n_wr = 0;
        rx_rd_data = 32'h5a5a_a5a5;
    end
    always @(posedge aclk) begin
        if (rx_wr_stb) begin
            n_wr       <= n_wr + 1;
            rx_rd_data <= rx_wr_data;
            lw_addr    <= rx_wr_addr;
            lw_sel     <= rx_chip_sel;
        end
    end
endmodule : rcac_rx_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bench: bus master, stream sink and chip model around the block.
// ****************************************************************
module tb_top;
    logic        aclk, aresetn, ce, sync_pin, soft_sync, stall, pchk;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        even_valid, even_ready, odd_valid, odd_ready, acq_even, acq_odd;
    logic        rx_wr_stb, gain_path_even, gain_path_odd;
    logic [19:0] s_axi_awaddr, s_axi_araddr, a;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx_wr_data, rx_rd_data, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rx_chip_sel, lw_sel;
    logic [13:0] adc_even, adc_odd, even_data, odd_data, decim_odd, pe;
    logic [2:0]  mode_even, mode_odd;
    logic [8:0]  acc_even, acc_odd;
    logic [4:0]  gain_even, gain_odd;
    logic [12:0] rx_wr_addr, lw_addr;
    logic [19:0] ra [6];
    logic [15:0] rm [6];
    logic [31:0] v [6];
    int          n_fail, checked, n_wr, k, n0;
    int          ne = 0;

    rcac_top i_dut (.*);
    rcac_rx_model i_chip (.aclk, .rx_wr_stb, .rx_wr_addr, .rx_wr_data, .rx_chip_sel,
        .rx_rd_data, .n_wr, .lw_addr, .lw_sel);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    function automatic logic [8:0] acc_exp(input int c);
        return (c > 7) ? 9'h100 : 9'(1 << c);
    endfunction : acc_exp

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wreg(input logic [19:0] wa, input logic [31:0] wd, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr  <= wa;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | (s_axi_awvalid & s_axi_awready);
            w = w | (s_axi_wvalid & s_axi_wready);
            s_axi_awvalid <= !aw;
            s_axi_wvalid  <= !w;
        end
        repeat ($urandom_range(0, 2)) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask : wreg

    task automatic rchk(input logic [19:0] qa, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr  <= qa;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom_range(0, 2)) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", s_axi_rresp, er);
    endtask : rchk

    task automatic sync_pulse();
        soft_sync <= 1'b1;
        @(posedge aclk);
        soft_sync <= 1'b0;
    endtask : sync_pulse

    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    always @(posedge aclk) begin
        even_ready <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
        odd_ready  <= 1'($urandom_range(0, 1));
        adc_even   <= 14'($urandom);
        adc_odd    <= 14'($urandom);
        if (even_valid && even_ready) begin
            if (pchk && ne != n0)
                chk("pattern", even_data, pe + 14'h1);
            pe <= even_data;
            ne <= ne + 1;
        end
    end

    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        results();
    end

    initial begin
        {ce, sync_pin, soft_sync, stall, pchk, even_ready, odd_ready} = 7'h41;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_even, adc_odd} = '0;
        s_axi_wstrb = 4'hf;
        n_fail = 0;
        checked = 0;
        n0 = 0;
        ra = '{rcac_pkg::OFS_WIN_EVEN, rcac_pkg::OFS_DEC_ODD, rcac_pkg::OFS_WIN_ODD,
            rcac_pkg::OFS_GAIN, rcac_pkg::OFS_CTRL_EVEN, rcac_pkg::OFS_CTRL_ODD};
        rm = '{16'hffff, rcac_pkg::MASK_DEC, 16'hffff, rcac_pkg::MASK_GAIN,
            rcac_pkg::MASK_CTRL, rcac_pkg::MASK_CTRL};
        void'($urandom(14));
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) begin
            v[i] = $urandom;
            rchk(ra[i], 32'(rcac_pkg::RST_REG), rcac_pkg::AXI_OKAY);
            wreg(ra[i], v[i], rcac_pkg::AXI_OKAY);
            rchk(ra[i], 32'(v[i][15:0] & rm[i]), rcac_pkg::AXI_OKAY);
        end
        repeat (2) @(posedge aclk);
        chk("decim", decim_odd, v[1][13:0]);
        chk("mode_even", mode_even, v[4][2:0]);
        chk("gain_even", {gain_path_even, gain_even}, {v[3][0], v[3][6:2]});
        chk("gain_odd", {gain_path_odd, gain_odd}, {v[3][1], v[3][11:7]});
        wreg(20'h10020, 32'h1, rcac_pkg::AXI_SLVERR);
        rchk(20'h10020, 32'h0, rcac_pkg::AXI_SLVERR);
        $display("registers done");
        for (int c = 0; c < 16; c++) begin
            wreg(rcac_pkg::OFS_CTRL_ODD, 32'((c << 3) | (c & 7)), rcac_pkg::AXI_OKAY);
            repeat (2) @(posedge aclk);
            chk("acc", acc_odd, acc_exp(c));
            chk("mode", mode_odd, c % 8);
        end
        $display("fields done");
        for (int i = 0; i < 3; i++) begin
            k = (i == 0) ? 1 : $urandom_range(3, 12);
            stall = i[0];
            pchk = !i[0];
            wreg(rcac_pkg::OFS_WIN_EVEN, 32'(k - 1), rcac_pkg::AXI_OKAY);
            wreg(rcac_pkg::OFS_CTRL_EVEN, 32'h0480, rcac_pkg::AXI_OKAY);
            n0 = ne;
            sync_pulse();
            for (int t = 0; t < 1000 && (t < 4 || acq_even || even_valid); t++)
                @(posedge aclk);
            chk("burst_words", ne - n0, k);
            chk("odd_off", {acq_odd, odd_valid}, 2'b00);
        end
        $display("burst done");
        stall = 1'b1;
        pchk = 1'b0;
        wreg(rcac_pkg::OFS_CTRL_EVEN, 32'h0680, rcac_pkg::AXI_OKAY);
        sync_pulse();
        repeat (40) @(posedge aclk);
        chk("free_run", acq_even, 1'b1);
        wreg(rcac_pkg::OFS_CTRL_EVEN, 32'h8680, rcac_pkg::AXI_OKAY);
        repeat (2) @(posedge aclk);
        chk("clear", acq_even, 1'b0);
        rchk(rcac_pkg::OFS_CTRL_EVEN, 32'h0680, rcac_pkg::AXI_OKAY);
        stall = 1'b0;
        wreg(rcac_pkg::OFS_CTRL_EVEN, 32'h0100, rcac_pkg::AXI_OKAY);
        sync_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("gate_on", acq_even, 1'b1);
        sync_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("gate_off", acq_even, 1'b0);
        $display("trigger done");
        for (int c = 0; c < 4; c++) begin
            a = rcac_pkg::OFS_RX_BASE + 20'(c * 32'h2000) + 20'($urandom_range(0, 1023) * 8);
            d = $urandom;
            k = n_wr;
            wreg(a, 32'(d[15:0]), rcac_pkg::AXI_OKAY);
            @(posedge aclk);
            chk("low_only", n_wr, k);
            wreg(a + 20'h4, 32'(d[31:16]), rcac_pkg::AXI_OKAY);
            @(posedge aclk);
            chk("chip_count", n_wr, k + 1);
            chk("chip_word", rx_rd_data, d);
            chk("chip_target", {lw_sel, lw_addr}, {c[1:0], a[12:0]});
            rchk(a, 32'(d[15:0]), rcac_pkg::AXI_OKAY);
            rchk(a + 20'h4, 32'(d[31:16]), rcac_pkg::AXI_OKAY);
        end
        $display("bridge done");
        results();
    end
endmodule : tb_top
`default_nettype wire
